//--- hw/sss_defines.svh
// register offsets, field positions and timing constants of the slot sequencer
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH
`define SSS_A_RES      8'h00
`define SSS_A_RES_END  8'h18
`define SSS_A_STATE    8'h21
`define SSS_A_FAULT    8'h22
`define SSS_A_BUSADDR  8'h23
`define SSS_A_CFG      8'h30
`define SSS_A_OV       8'h30
`define SSS_A_UV       8'h40
`define SSS_A_CRIT     8'h50
`define SSS_A_MONEN_LO 8'h5c
`define SSS_A_MONEN_HI 8'h5d
`define SSS_A_GPMASK   8'h60
`define SSS_A_SWEN     8'h73
`define SSS_A_PDMODE   8'h75
`define SSS_A_RSTTO    8'h76
`define SSS_A_DLY      8'h77
`define SSS_A_OUTCFG   8'h80
`define SSS_OC_AH      4
`define SSS_OC_OD      5
`define SSS_ST_SMON    5'h0d
`define SSS_ST_PFAULT  5'h0e
`define SSS_ST_PMON    5'h0f
`define SSS_ST_SFAULT  5'h10
`define SSS_LAST_SLOT  4'hc
`define SSS_CLK_MHZ    200
`define SSS_BOOT_US    350
`define SSS_CYCLE_US   50
`define SSS_DLY_US0    25
`define SSS_DLY_US1    500
`define SSS_DLY_US2    1000
`define SSS_DLY_US3    2000
`define SSS_DLY_US4    3000
`define SSS_DLY_US5    4000
`define SSS_DLY_US6    6000
`define SSS_DLY_US7    8000
`define SSS_DLY_US8    10000
`define SSS_DLY_US9    12000
`define SSS_DLY_US10   25000
`define SSS_DLY_US11   100000
`define SSS_DLY_US12   200000
`define SSS_DLY_US13   400000
`define SSS_DLY_US14   800000
`define SSS_DLY_US15   1600000
`endif

//--- hw/sss_pkg.sv
// types of the slot sequencer
`default_nettype none
package sss_pkg;
    typedef enum logic [2:0] {
        SSS_BOOT_CLR, SSS_BOOT_COPY, SSS_SLOT, SSS_RST_WAIT, SSS_MON, SSS_PDN, SSS_FAULT
    } sss_phase_e;
    typedef struct packed {
        logic       req;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sss_regreq_s;
    typedef struct packed {
        sss_phase_e       phase;
        logic [3:0]       slot;
        logic [31:0]      cnt;
        logic [7:0]       idx;
        logic [255:0][7:0] cfg;
        logic [11:0][9:0] res;
        logic [3:0]       ch;
        logic             adc_busy;
        logic             adc_start;
        logic             cmp;
        logic             scanned;
        logic [7:0]       fault_vec;
        logic [1:0]       page;
        logic [1:0]       bus_addr;
        logic [1:0]       a0_s1;
        logic [1:0]       a0_s2;
        logic             en_s1;
        logic             en_s2;
        logic [7:0]       rdata;
        logic             ack;
        logic             nack;
        logic [11:0]      on;
        logic [11:0]      sup_o;
        logic [11:0]      sup_oe;
        logic [7:0]       gp_o;
        logic [7:0]       gp_oe;
        logic             rst_n;
        logic             log_trig;
        logic [16:0]      boot_age;
    } sss_state_s;
endpackage
`default_nettype wire

//--- hw/sss_sequencer.sv
// slot sequencer: boot copy, slot power-up/down, monitoring, status register
//
// Contract
// - power-up starts after boot only with enable pin high and software enable 1
// - monitoring begins only after a completed power-up sequence
// - monitoring scans enabled inputs, storing each 10-bit result separately
// - each finished scan compares results with over and under thresholds
// - each general-purpose pin asserts on its programmed fault mask
// - configured fault shuts down and triggers the fault logger
// - three pages, switched only by page-select commands
// - power-on reset clears all volatile registers before flash loading
// - boot masks monitor faults and copies flash into registers
// - boot ends within 350 us; register access refused until then
// - reset low through boot, released after sequence plus timeout in bounds
// - pins and supply enables high impedance until boot completes
// - power-up turns slots on ascending from 1 to 12
// - outputs sharing a slot switch on together
// - every slot has its own 4-bit delay field, two slots per register, 25 us to 1.6 s
// - reverse power-down turns slots off descending from 12
// - a config bit picks simultaneous or reverse power-down
// - sequencer state readable in a five-bit status field
// - codes: slots 0-12 binary, 13 sec mon, 14 pri fault, 15 pri mon, 16 sec fault
// - enable pin low deasserts every output
// - bus address pin sampled once after power-on reset, then held
// - each supply enable selectable active-high/low and push-pull/open-drain
// - slot 0 drives nothing, waits for both enables, counts delay, goes slot 1
// - slot delay is a 4-bit code, 0000 shortest to 1111 for 1.6 s
`timescale 1ns/1ps
`default_nettype none
`include "sss_defines.svh"
module sss_sequencer import sss_pkg::*; #(
    parameter int CYC_PER_US = `SSS_CLK_MHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire sss_regreq_s reg_bus,
    output logic [7:0]       reg_rdata,
    output logic             reg_ack,
    output logic             reg_nack,
    input  wire logic        page_req,
    input  wire logic [1:0]  page_sel,
    output logic [7:0]       flash_addr,
    input  wire logic [7:0]  flash_rdata,
    input  wire logic        enable_pin_voltage,
    input  wire logic [1:0]  bus_address_select_pin,
    output logic [1:0]       bus_address,
    output logic [3:0]       adc_sel,
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [9:0]  adc_data,
    output logic [11:0]      supply_en,
    output logic [11:0]      supply_en_oe,
    output logic [7:0]       gpio_out,
    output logic [7:0]       gpio_oe,
    output logic             reset_out_n,
    output logic             fault_log_trigger
);
    localparam int BOOT_CYC = `SSS_BOOT_US * CYC_PER_US;

    // upper bound keeps 1.6 s worth of cycles inside 32 bits
    if (CYC_PER_US < 1 || CYC_PER_US > 1000) begin : g_chk
        $error("CYC_PER_US out of range");
    end

    sss_state_s s;
    sss_state_s n;

    function automatic logic [31:0] dly_cyc(input logic [3:0] code);
        int us;
        case (code)
            4'h0: us = `SSS_DLY_US0;
            4'h1: us = `SSS_DLY_US1;
            4'h2: us = `SSS_DLY_US2;
            4'h3: us = `SSS_DLY_US3;
            4'h4: us = `SSS_DLY_US4;
            4'h5: us = `SSS_DLY_US5;
            4'h6: us = `SSS_DLY_US6;
            4'h7: us = `SSS_DLY_US7;
            4'h8: us = `SSS_DLY_US8;
            4'h9: us = `SSS_DLY_US9;
            4'ha: us = `SSS_DLY_US10;
            4'hb: us = `SSS_DLY_US11;
            4'hc: us = `SSS_DLY_US12;
            4'hd: us = `SSS_DLY_US13;
            4'he: us = `SSS_DLY_US14;
            default: us = `SSS_DLY_US15;
        endcase
        return 32'(us * CYC_PER_US);
    endfunction

    // two slots share one delay byte, even slot in the low nibble
    function automatic logic [3:0] slot_code(input sss_state_s q, input logic [3:0] k);
        logic [7:0] b;
        b = q.cfg[`SSS_A_DLY + 8'(k[3:1])];
        return k[0] ? b[7:4] : b[3:0];
    endfunction

    function automatic sss_state_s go_down(input sss_state_s q);
        sss_state_s r;
        r = q;
        r.rst_n = 1'b0;
        r.cnt   = '0;
        if (q.cfg[`SSS_A_PDMODE][0]) begin
            r.phase = SSS_PDN;
            r.slot  = `SSS_LAST_SLOT;
        end else begin
            r.phase = SSS_SLOT;
            r.slot  = 4'h0;
        end
        return r;
    endfunction

    function automatic logic [4:0] st_code(input sss_state_s q);
        unique case (q.phase)
            SSS_SLOT, SSS_PDN: return {1'b0, q.slot};
            SSS_RST_WAIT:      return {1'b0, `SSS_LAST_SLOT};
            SSS_MON:           return `SSS_ST_PMON;
            SSS_FAULT:         return `SSS_ST_PFAULT;
            SSS_BOOT_CLR, SSS_BOOT_COPY: return 5'h00;
        endcase
    endfunction

    function automatic logic [7:0] rd(input sss_state_s q, input logic [7:0] a);
        logic [9:0] r;
        r = q.res[a[4:1]];
        if (q.page != 2'h0) return 8'h00;
        if (a < `SSS_A_RES_END) return a[0] ? {6'h00, r[1:0]} : r[9:2];
        if (a == `SSS_A_STATE) return {3'h0, st_code(q)};
        if (a == `SSS_A_FAULT) return q.fault_vec;
        if (a == `SSS_A_BUSADDR) return {6'h00, q.bus_addr};
        if (a >= `SSS_A_CFG) return q.cfg[a];
        return 8'h00;
    endfunction

    always_comb begin : comb
        logic        en_ok;
        logic        booted;
        logic        adv;
        logic        lvl;
        logic        od;
        logic [3:0]  os;
        logic [11:0] ov;
        logic [11:0] uv;
        logic [11:0] mon_en;
        logic [11:0] crit;
        n      = s;
        en_ok  = 1'b0;
        adv    = 1'b0;
        lvl    = 1'b0;
        od     = 1'b0;
        os     = 4'h0;
        ov     = '0;
        uv     = '0;
        crit   = '0;
        booted = !(s.phase inside {SSS_BOOT_CLR, SSS_BOOT_COPY});
        mon_en = {s.cfg[`SSS_A_MONEN_HI][3:0], s.cfg[`SSS_A_MONEN_LO]};
        n.ack       = 1'b0;
        n.nack      = 1'b0;
        n.adc_start = 1'b0;
        n.log_trig  = 1'b0;
        n.cmp       = 1'b0;
        n.en_s1     = enable_pin_voltage;
        n.en_s2     = s.en_s1;
        n.a0_s1     = bus_address_select_pin;
        n.a0_s2     = s.a0_s1;
        en_ok       = s.en_s2 & s.cfg[`SSS_A_SWEN][0];
        if (!booted) begin
            n.boot_age = s.boot_age + 17'h1;
        end
        for (int c = 0; c < 12; c++) begin
            crit[c] = s.cfg[`SSS_A_CRIT + c][0];
            if (s.cmp && mon_en[c]) begin
                ov[c] = s.res[c][9:2] > s.cfg[`SSS_A_OV + c];
                uv[c] = s.res[c][9:2] < s.cfg[`SSS_A_UV + c];
            end
        end
        if (s.cmp) begin
            n.fault_vec[1:0] = {|uv, |ov};
            n.scanned        = 1'b1;
        end
        // scan runs only once sequencing is done, so boot can raise nothing
        if (s.phase inside {SSS_RST_WAIT, SSS_MON}) begin
            if (!s.adc_busy) begin
                if (mon_en[s.ch]) begin
                    n.adc_start = 1'b1;
                    n.adc_busy  = 1'b1;
                end else begin
                    adv = 1'b1;
                end
            end else if (adc_done) begin
                n.res[s.ch] = adc_data;
                n.adc_busy  = 1'b0;
                adv         = 1'b1;
            end
            if (adv) begin
                n.ch  = (s.ch == 4'hb) ? 4'h0 : s.ch + 4'h1;
                n.cmp = (s.ch == 4'hb);
            end
        end else begin
            n.ch       = 4'h0;
            n.adc_busy = 1'b0;
        end
        unique case (s.phase)
            SSS_BOOT_CLR: begin
                n.cfg   = '0;
                n.res   = '0;
                n.idx   = `SSS_A_CFG;
                n.phase = SSS_BOOT_COPY;
            end
            SSS_BOOT_COPY: begin
                n.cfg[s.idx] = flash_rdata;
                n.idx        = s.idx + 8'h1;
                if (s.idx == 8'hff) begin
                    n.phase    = SSS_SLOT;
                    n.bus_addr = s.a0_s2;
                end
            end
            SSS_SLOT: begin
                if (!en_ok) begin
                    n.cnt = '0;
                    if (s.slot != 4'h0) begin
                        n = go_down(n);
                    end
                end else if (s.cnt >= dly_cyc(slot_code(s, s.slot))) begin
                    n.cnt = '0;
                    if (s.slot == `SSS_LAST_SLOT) begin
                        n.phase   = SSS_RST_WAIT;
                        n.scanned = 1'b0;
                    end else begin
                        n.slot = s.slot + 4'h1;
                    end
                end else begin
                    n.cnt = s.cnt + 32'h1;
                end
            end
            SSS_RST_WAIT: begin
                if (!en_ok) begin
                    n = go_down(n);
                end else if (s.cmp && (|ov || |uv)) begin
                    n.cnt = '0;
                end else if (s.scanned && s.fault_vec[1:0] == 2'h0
                             && s.cnt >= dly_cyc(s.cfg[`SSS_A_RSTTO][3:0])) begin
                    n.phase = SSS_MON;
                    n.rst_n = 1'b1;
                end else begin
                    n.cnt = s.cnt + 32'h1;
                end
            end
            SSS_MON: begin
                if (!en_ok) begin
                    n = go_down(n);
                end else if (s.cmp && |((ov | uv) & crit)) begin
                    n.phase        = SSS_FAULT;
                    n.log_trig     = 1'b1;
                    n.fault_vec[3] = 1'b1;
                    n.rst_n        = 1'b0;
                end
            end
            SSS_PDN: begin
                if (s.cnt >= dly_cyc(slot_code(s, s.slot))) begin
                    n.cnt = '0;
                    if (s.slot == 4'h1) begin
                        n.phase = SSS_SLOT;
                        n.slot  = 4'h0;
                    end else begin
                        n.slot = s.slot - 4'h1;
                    end
                end else begin
                    n.cnt = s.cnt + 32'h1;
                end
            end
            SSS_FAULT: begin
                // latched until an enable is dropped
                if (!en_ok) begin
                    n.phase        = SSS_SLOT;
                    n.slot         = 4'h0;
                    n.cnt          = '0;
                    n.fault_vec[3] = 1'b0;
                end
            end
        endcase
        for (int o = 0; o < 12; o++) begin
            os = s.cfg[`SSS_A_OUTCFG + o][3:0];
            od = s.cfg[`SSS_A_OUTCFG + o][`SSS_OC_OD];
            unique case (s.phase)
                SSS_SLOT:              n.on[o] = os != 4'h0 && os <= s.slot;
                // a cut power-up must not light the slots it never reached
                SSS_PDN:               n.on[o] = s.on[o] && os < s.slot;
                SSS_RST_WAIT, SSS_MON: n.on[o] = os != 4'h0;
                default:               n.on[o] = 1'b0;
            endcase
            n.on[o]     = n.on[o] & s.en_s2;
            lvl         = n.on[o] == s.cfg[`SSS_A_OUTCFG + o][`SSS_OC_AH];
            n.sup_o[o]  = od ? 1'b0 : lvl;
            n.sup_oe[o] = booted && (!od || !lvl);
        end
        for (int g = 0; g < 8; g++) begin
            n.gp_o[g]  = booted && s.en_s2 && |(s.fault_vec & s.cfg[`SSS_A_GPMASK + g]);
            n.gp_oe[g] = booted;
        end
        if (reg_bus.req) begin
            if (!booted) begin
                n.nack = 1'b1;
            end else begin
                n.ack   = 1'b1;
                n.rdata = rd(s, reg_bus.addr);
                if (reg_bus.wr && s.page == 2'h0 && reg_bus.addr >= `SSS_A_CFG) begin
                    n.cfg[reg_bus.addr] = reg_bus.wdata;
                end
            end
        end
        if (page_req && booted && page_sel != 2'h3) begin
            n.page = page_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata         = s.rdata;
    assign reg_ack           = s.ack;
    assign reg_nack          = s.nack;
    assign flash_addr        = s.idx;
    assign bus_address       = s.bus_addr;
    assign adc_sel           = s.ch;
    assign adc_start         = s.adc_start;
    assign supply_en         = s.sup_o;
    assign supply_en_oe      = s.sup_oe;
    assign gpio_out          = s.gp_o;
    assign gpio_oe           = s.gp_oe;
    assign reset_out_n       = s.rst_n;
    assign fault_log_trigger = s.log_trig;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic booting;
    assign booting = s.phase inside {SSS_BOOT_CLR, SSS_BOOT_COPY};

    property p_refuse;
        reg_bus.req && booting |=> reg_nack && !reg_ack;
    endproperty
    a_refuse: assert property (p_refuse) else $error("access during boot not refused");

    property p_boot_len;
        booting |-> s.boot_age < 17'(BOOT_CYC);
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot too long");

    property p_hiz;
        booting |-> supply_en_oe == '0 && gpio_oe == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pins driven during boot");

    property p_rst_low;
        (booting || s.phase == SSS_SLOT) |-> !reset_out_n;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset released early");

    property p_clear;
        s.phase == SSS_BOOT_COPY && s.idx == `SSS_A_CFG |-> s.cfg == '0 && s.res == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("registers not cleared");

    property p_mon_entry;
        s.phase == SSS_MON && $past(s.phase) != SSS_MON |-> $past(s.phase) == SSS_RST_WAIT;
    endproperty
    a_mon_entry: assert property (p_mon_entry) else $error("monitoring without sequence");

    property p_ascend;
        s.phase == SSS_SLOT && $past(s.phase) == SSS_SLOT && s.slot != $past(s.slot)
            && s.slot != 4'h0 |-> s.slot == $past(s.slot) + 4'h1;
    endproperty
    a_ascend: assert property (p_ascend) else $error("slot order broken");

    property p_rev_start;
        s.phase == SSS_PDN && $past(s.phase) != SSS_PDN |-> s.slot == `SSS_LAST_SLOT;
    endproperty
    a_rev_start: assert property (p_rev_start) else $error("reverse not from slot 12");

    property p_pdn_off;
        s.phase == SSS_PDN |=> (s.on & ~$past(s.on)) == '0;
    endproperty
    a_pdn_off: assert property (p_pdn_off) else $error("output on during power-down");

    property p_en_low;
        !s.en_s2 |=> s.on == '0 && gpio_out == '0 && !reset_out_n;
    endproperty
    a_en_low: assert property (p_en_low) else $error("output on with enable low");

    property p_status;
        rd(s, `SSS_A_STATE) <= {3'h0, `SSS_ST_SFAULT};
    endproperty
    a_status: assert property (p_status) else $error("reserved status code");

    property p_wait_en;
        s.phase == SSS_SLOT && s.slot == 4'h0 && !(s.en_s2 && s.cfg[`SSS_A_SWEN][0])
            |=> s.slot == 4'h0 && s.cnt == '0;
    endproperty
    a_wait_en: assert property (p_wait_en) else $error("slot 0 left without enables");

    c_mon: cover property (s.phase == SSS_MON);
    c_fault: cover property (fault_log_trigger);
    c_pdn: cover property (s.phase == SSS_PDN && s.slot == 4'h1);
endmodule // sss_sequencer
`default_nettype wire

//--- test/sss_supply_model.sv
// far side of the slot sequencer: flash image and monitor converter
`timescale 1ns/1ps
`default_nettype none
module sss_supply_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [7:0] flash_addr,
    output logic [7:0]      flash_rdata,
    input  wire logic [3:0] adc_sel,
    input  wire logic       adc_start,
    output logic            adc_done,
    output logic [9:0]      adc_data
);
    logic [2:0] wait_ff;
    logic [3:0] o;
    // image copied at boot: limits, enables, slot map
    always_comb begin
        o = flash_addr[3:0];
        flash_rdata = 8'h00;
        case (flash_addr)
            8'h5c: flash_rdata = 8'hff;
            8'h5d: flash_rdata = 8'h0f;
            8'h73: flash_rdata = 8'h01;
            8'h75: flash_rdata = 8'h01;
            8'h79: flash_rdata = 8'h10;
            default: ;
        endcase
        if (flash_addr >= 8'h30 && flash_addr < 8'h3c)
            flash_rdata = 8'hf0;
        if (flash_addr >= 8'h40 && flash_addr < 8'h4c)
            flash_rdata = 8'h10;
        // output 2 active low, output 3 open drain, output 11 in slot 12
        if (flash_addr >= 8'h80 && flash_addr < 8'h8c)
            flash_rdata = {2'b00, o == 4'h3, o != 4'h2,
                           o == 4'h0 ? 4'h1 : o == 4'hb ? 4'hc : o};
    end
    // conversion takes three cycles
    always_ff @(posedge core_clk) begin
        if (rst)
            wait_ff <= 3'h0;
        else if (adc_start)
            wait_ff <= 3'h3;
        else if (wait_ff != 3'h0)
            wait_ff <= wait_ff - 3'h1;
    end
    assign adc_done = wait_ff == 3'h1;
    // data is only meaningful with done; otherwise inverted
    assign adc_data = adc_done ? {4'h4, adc_sel, 2'b01} : ~{4'h4, adc_sel, 2'b01};
endmodule // sss_supply_model
`default_nettype wire

//--- test/supply_slot_sequencer_bench.sv
// self-checking bench of the slot sequencer
`timescale 1ns/1ps
`default_nettype none
module supply_slot_sequencer_bench import sss_pkg::*; ;
    sss_regreq_s reg_bus;
    logic [7:0]  reg_rdata, flash_addr, flash_rdata, gpio_out, gpio_oe, st, pv;
    logic [1:0]  page_sel, bus_address_select_pin, bus_address;
    logic [3:0]  adc_sel;
    logic [9:0]  adc_data;
    logic [11:0] supply_en, supply_en_oe, prv, cur;
    logic [15:0] seen;
    logic        core_clk, rst, reg_ack, reg_nack, page_req, enable_pin_voltage;
    logic        adc_start, adc_done, reset_out_n, fault_log_trigger, arm, ok;
    int          miscompares, n_tests, cyc, en_t, rst_t, log_n, n;
    int          on_t[12], off_t[12];

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    sss_sequencer #(.CYC_PER_US(1)) dut (.core_clk(core_clk), .rst(rst),
        .reg_bus(reg_bus), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_nack(reg_nack),
        .page_req(page_req), .page_sel(page_sel), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .enable_pin_voltage(enable_pin_voltage),
        .bus_address_select_pin(bus_address_select_pin), .bus_address(bus_address),
        .adc_sel(adc_sel), .adc_start(adc_start), .adc_done(adc_done),
        .adc_data(adc_data), .supply_en(supply_en), .supply_en_oe(supply_en_oe),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .reset_out_n(reset_out_n),
        .fault_log_trigger(fault_log_trigger));
    sss_supply_model model (.core_clk(core_clk), .rst(rst), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata), .adc_sel(adc_sel), .adc_start(adc_start),
        .adc_done(adc_done), .adc_data(adc_data));

    // asserted view per output, honouring polarity and open drain
    function automatic logic [11:0] asv();
        for (int o = 0; o < 12; o++)
            asv[o] = o == 2 ? supply_en_oe[o] & ~supply_en[o]
                   : o == 3 ? ~supply_en_oe[o] : supply_en_oe[o] & supply_en[o];
    endfunction

    // sampled mid-cycle so registered outputs have settled
    always @(negedge core_clk) begin
        cyc++;
        cur = asv();
        if (arm) begin
            for (int o = 0; o < 12; o++) begin
                if (cur[o] && !prv[o]) on_t[o] = cyc;
                if (!cur[o] && prv[o]) off_t[o] = cyc;
            end
            if (reset_out_n === 1'b1 && rst_t < 0) rst_t = cyc;
        end
        prv = cur;
        if (fault_log_trigger === 1'b1) log_n++;
    end

    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %0h, expected %0h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge core_clk);
        reg_bus <= '{1'b1, w, a, d};
        @(posedge core_clk);
        reg_bus.req <= 1'b0;
        #1 ok = reg_ack === 1'b1;
        st = reg_rdata;
    endtask
    task automatic rd(input logic [7:0] a, e);
        acc(1'b0, a, 8'h00);
        chk({31'h0, ok}, 32'h1);
        chk(st, e);
    endtask
    task automatic wr(input logic [7:0] a, d);
        acc(1'b1, a, d);
        chk({31'h0, ok}, 32'h1);
    endtask
    task automatic pgr(input logic [1:0] s, input logic [7:0] e);
        @(posedge core_clk);
        page_req <= 1'b1;
        page_sel <= s;
        @(posedge core_clk);
        page_req <= 1'b0;
        rd(8'h73, e);
    endtask
    task automatic wait_st(input logic [7:0] e);
        n = 0;
        do begin
            acc(1'b0, 8'h21, 8'h00);
            n++;
        end while (st !== e && n < 1500);
        chk(st, e);
    endtask
    task automatic clr();
        for (int o = 0; o < 12; o++) begin
            on_t[o] = -1;
            off_t[o] = -1;
        end
        rst_t = -1;
    endtask
    task automatic test_done();
        $display("counts: %0d compared, %0d unexpected", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        test_done();
    end

    initial begin
        int e;
        rst = 1'b1;
        reg_bus = '0;
        page_req = 1'b0;
        page_sel = 2'h0;
        enable_pin_voltage = 1'b0;
        bus_address_select_pin = 2'h2;
        arm = 1'b0;
        {miscompares, n_tests, cyc, log_n} = '0;
        clr();
        repeat (5) @(posedge core_clk);
        chk({reset_out_n, supply_en_oe, gpio_oe}, 0);
        rst <= 1'b0;
        acc(1'b0, 8'h21, 8'h00);
        chk({ok, reg_nack}, 2'b01);
        chk({supply_en_oe, gpio_oe}, 0);
        n = 0;
        do begin
            acc(1'b0, 8'h21, 8'h00);
            n++;
        end while (!ok && n < 400);
        chk(n <= 175 ? 1 : n, 1);
        @(posedge core_clk);
        bus_address_select_pin <= 2'h1;
        rd(8'h21, 8'h00);
        rd(8'h73, 8'h01);
        rd(8'h79, 8'h10);
        rd(8'h44, 8'h10);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h55);
        rd(8'h00, 8'h00);
        rd(8'h23, 8'h02);
        chk(bus_address, 2'h2);
        pgr(2'h1, 8'h00);
        pgr(2'h0, 8'h01);
        pgr(2'h3, 8'h01);
        $display("test boot ended");
        repeat (60) @(posedge core_clk);
        chk(asv(), 0);
        arm = 1'b1;
        en_t = cyc;
        enable_pin_voltage <= 1'b1;
        seen = '0;
        pv = 8'h00;
        n = 0;
        do begin
            acc(1'b0, 8'h21, 8'h00);
            chk(st >= pv && st <= 8'h0f ? 8'h00 : st, 8'h00);
            seen[st[3:0]] = 1'b1;
            pv = st;
            n++;
        end while (st !== 8'h0f && n < 1000);
        chk(seen, 16'h9fff);
        chk(rst_t > on_t[11] && on_t[11] > 0 ? 1 : rst_t, 1);
        chk(on_t[0] - en_t >= 25 ? 1 : on_t[0] - en_t, 1);
        chk(on_t[1], on_t[0]);
        for (int o = 2; o < 12; o++) begin
            e = o == 6 ? 500 : o == 11 ? 50 : 25;
            n = on_t[o] - on_t[o-1];
            chk(n inside {[e:e+3]} ? e : n, e);
        end
        for (int c = 0; c < 12; c++) begin
            rd(8'(2 * c), 8'h40 + 8'(c));
            rd(8'(2 * c + 1), 8'h01);
        end
        $display("test power-up ended");
        clr();
        wr(8'h73, 8'h00);
        repeat (1200) @(posedge core_clk);
        chk(off_t[1], off_t[0]);
        for (int o = 2; o < 12; o++)
            chk(off_t[o-1] > off_t[o] && off_t[o] > 0 ? 1 : 0, 1);
        wr(8'h73, 8'h01);
        wait_st(8'h0f);
        wr(8'h75, 8'h00);
        clr();
        wr(8'h73, 8'h00);
        repeat (50) @(posedge core_clk);
        chk(off_t[0] > 0 ? 1 : 0, 1);
        for (int o = 1; o < 12; o++)
            chk(off_t[o], off_t[0]);
        wr(8'h73, 8'h01);
        wait_st(8'h0f);
        @(posedge core_clk);
        enable_pin_voltage <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({asv(), gpio_oe & gpio_out}, 0);
        enable_pin_voltage <= 1'b1;
        wait_st(8'h0f);
        $display("test power-down ended");
        wr(8'h60, 8'h01);
        wr(8'h53, 8'h01);
        wr(8'h44, 8'hff);
        log_n = 0;
        wr(8'h33, 8'h20);
        repeat (300) @(posedge core_clk);
        chk(log_n, 1);
        chk(asv(), 0);
        chk(gpio_out[0] & gpio_oe[0], 1);
        rd(8'h22, 8'h0b);
        rd(8'h21, 8'h0e);
        $display("test fault ended");
        test_done();
    end
endmodule // supply_slot_sequencer_bench
`default_nettype wire
